// >>> include/acc_defines.vh
`ifndef ACC_DEFINES_VH
`define ACC_DEFINES_VH
// register byte offsets
`define ACC_OFS_CTRL_A      8'h00
`define ACC_OFS_CTRL_B      8'h04
`define ACC_OFS_RESULT      8'h08
`define ACC_OFS_FLAG        8'h0c
`define ACC_OFS_ENABLE      8'h10
// conv_control_a fields
`define ACC_BIT_ON          0
`define ACC_BIT_GO          1
`define ACC_CHS_LSB         2
`define ACC_CHS_MSB         5
// conv_control_b field
`define ACC_CKS_LSB         4
`define ACC_CKS_MSB         6
// flag / enable bit position
`define ACC_BIT_DONE        0
// reset values
`define ACC_RST_CHS         4'h0
`define ACC_RST_CKS         3'h0
`define ACC_RST_RESULT      8'h00
// channel count, 14 inputs
`define ACC_NUM_CHANNELS    4'he
// conversion clock selections
`define ACC_CKS_DIV2        3'h0
`define ACC_CKS_DIV4        3'h4
`define ACC_CKS_DIV8        3'h1
`define ACC_CKS_DIV16       3'h5
`define ACC_CKS_DIV32       3'h2
`define ACC_CKS_DIV64       3'h6
// bit periods per conversion and resolved bits
`define ACC_PERIODS         4'ha
`define ACC_RES_BITS        8
// axi responses
`define ACC_RESP_OKAY       2'h0
`define ACC_RESP_SLVERR     2'h2
`endif

// >>> src/acc_conv_ctrl.v
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "acc_defines.vh"
// What this block does
// - select field picks divider or rc clock
// - done flag sets after every completed conversion, not on abort
// - irq when flag and enable both set
// - only rc clock converts during sleep
// - completion irq in sleep wakes device
// - converter works only while converter_on set
// - writing go starts, reads one while busy
// - finish clears go, sets flag, loads result
// - clearing go aborts, stores partial result if on stays set
// - unresolved bits copy last converted bit
// - reset returns all registers, converter off
// - conversion lasts ten bit periods
// - channel select routes one of fourteen inputs
module acc_conv_ctrl
(
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        rc_tick,
    input  wire        sleep_active,
    input  wire        cmp_above,
    output reg         converter_on,
    output reg  [3:0]  channel_select,
    output wire        sample_hold,
    output wire [7:0]  dac_trial,
    output reg         conv_irq,
    output reg         wake_request
);
    reg  [2:0]  conv_clock_select;
    reg  [7:0]  conv_result;
    reg         conv_done_flag;
    reg         conv_irq_enable;
    reg  [7:0]  aw_addr_reg;
    reg         aw_have_reg;
    reg  [7:0]  w_data_reg;
    reg         w_have_reg;
    reg         keep_partial_reg;
    wire        wr_fire;
    wire        wr_a;
    wire        wr_b;
    wire        wr_flag;
    wire        wr_en;
    wire        start;
    wire        stop;
    wire        busy;
    wire        tick;
    wire        sar_done;
    wire        sar_aborted;
    wire [7:0]  sar_result;

    // decode shared by the read and write paths
    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `ACC_OFS_CTRL_A) || (a == `ACC_OFS_CTRL_B) ||
                     (a == `ACC_OFS_RESULT) || (a == `ACC_OFS_FLAG) ||
                     (a == `ACC_OFS_ENABLE);
        end
    endfunction

    // write path: address and data latched in either order
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 8'h00;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ACC_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid
                             && !s_axi_bvalid;
            s_axi_wready  <= !w_have_reg && !s_axi_wready && s_axi_wvalid
                             && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_reg <= 1'b1;
                // only the low byte holds data; other lanes are ignored
                w_data_reg <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
            end
            if (wr_fire)
            begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(aw_addr_reg) ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
    assign wr_a    = wr_fire && (aw_addr_reg == `ACC_OFS_CTRL_A);
    assign wr_b    = wr_fire && (aw_addr_reg == `ACC_OFS_CTRL_B);
    assign wr_flag = wr_fire && (aw_addr_reg == `ACC_OFS_FLAG);
    assign wr_en   = wr_fire && (aw_addr_reg == `ACC_OFS_ENABLE);

    // go only counts when the converter was already on
    assign start = wr_a && w_data_reg[`ACC_BIT_GO] && converter_on && !busy;
    // clearing go or powering down ends the conversion
    assign stop  = busy && ((wr_a && !w_data_reg[`ACC_BIT_GO]) ||
                            (wr_a && !w_data_reg[`ACC_BIT_ON]));

    // control registers; reset turns the converter off
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            converter_on      <= 1'b0;
            channel_select    <= `ACC_RST_CHS;
            conv_clock_select <= `ACC_RST_CKS;
            conv_irq_enable   <= 1'b0;
            keep_partial_reg  <= 1'b0;
        end
        else
        begin
            if (wr_a)
            begin
                converter_on <= w_data_reg[`ACC_BIT_ON];
                // codes past the last input are not stored
                if (w_data_reg[`ACC_CHS_MSB:`ACC_CHS_LSB] < `ACC_NUM_CHANNELS)
                    channel_select <= w_data_reg[`ACC_CHS_MSB:`ACC_CHS_LSB];
            end
            if (wr_b)
                conv_clock_select <= w_data_reg[`ACC_CKS_MSB:`ACC_CKS_LSB];
            if (wr_en)
                conv_irq_enable <= w_data_reg[`ACC_BIT_DONE];
            // a power-down abort leaves the old result in place
            if (stop)
                keep_partial_reg <= w_data_reg[`ACC_BIT_ON];
        end
    end

    // completion and partial results; hardware set beats software clear
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            conv_result    <= `ACC_RST_RESULT;
            conv_done_flag <= 1'b0;
        end
        else
        begin
            if (sar_done)
                conv_result <= sar_result;
            else if (sar_aborted && keep_partial_reg)
                conv_result <= sar_result;
            if (sar_done)
                conv_done_flag <= 1'b1; // set on every completion
            else if (wr_flag)
                conv_done_flag <= w_data_reg[`ACC_BIT_DONE]; // cleared by software
        end
    end

    // interrupt request and wake from sleep
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            conv_irq     <= 1'b0;
            wake_request <= 1'b0;
        end
        else
        begin
            conv_irq     <= conv_done_flag && conv_irq_enable;
            wake_request <= conv_done_flag && conv_irq_enable && sleep_active;
        end
    end

    // read path: one read at a time, answer one cycle after address
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `ACC_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= mapped({s_axi_araddr[7:2], 2'b00}) ?
                                `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
                case ({s_axi_araddr[7:2], 2'b00})
                    `ACC_OFS_CTRL_A:
                        // go reads as one while converting
                        s_axi_rdata <= {26'h0, channel_select, busy, converter_on};
                    `ACC_OFS_CTRL_B:
                        s_axi_rdata <= {25'h0, conv_clock_select, 4'h0};
                    `ACC_OFS_RESULT:
                        s_axi_rdata <= {24'h0, conv_result};
                    `ACC_OFS_FLAG:
                        s_axi_rdata <= {31'h0, conv_done_flag};
                    `ACC_OFS_ENABLE:
                        s_axi_rdata <= {31'h0, conv_irq_enable};
                    default:
                        s_axi_rdata <= 32'h00000000;
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // bit period source, stalls in sleep unless rc is chosen
    acc_tad_gen u_tad
    (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .clock_select (conv_clock_select),
        .rc_tick      (rc_tick),
        .sleep_active (sleep_active),
        .run          (busy),
        .tick         (tick)
    );

    // successive approximation sequencer
    acc_sar u_sar
    (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .start     (start),
        .stop      (stop),
        .tick      (tick),
        .cmp_above (cmp_above),
        .busy      (busy),
        .done      (sar_done),
        .aborted   (sar_aborted),
        .result    (sar_result),
        .trial     (dac_trial),
        .sample    (sample_hold)
    );
endmodule
`default_nettype wire

// >>> src/acc_sar.v
`timescale 1ns/10ps
`default_nettype none
`include "acc_defines.vh"
module acc_sar
(
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       start,
    input  wire       stop,
    input  wire       tick,
    input  wire       cmp_above,
    output wire       busy,
    output reg        done,
    output reg        aborted,
    output wire [7:0] result,
    output reg  [7:0] trial,
    output reg        sample
);
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_SAMP = 3'h2;
    localparam [2:0] ST_CONV = 3'h4;

    reg  [2:0] state_reg;
    reg  [3:0] period_reg;
    reg  [7:0] code_reg;
    reg  [7:0] mask_reg;
    reg  [7:0] probe_reg;
    reg        last_reg;
    genvar     i;

    assign busy = !state_reg[0];

    // unresolved bits copy the last converted bit
    generate
        for (i = 0; i < `ACC_RES_BITS; i = i + 1)
        begin : g_fill
            assign result[i] = mask_reg[i] ? code_reg[i] : last_reg;
        end
    endgenerate

    // one bit per period from the msb, ten periods in all
    always @(posedge aclk)
    begin
        done    <= 1'b0;
        aborted <= 1'b0;
        if (!aresetn)
        begin
            state_reg  <= ST_IDLE;
            period_reg <= 4'h0;
            code_reg   <= 8'h00;
            mask_reg   <= 8'h00;
            probe_reg  <= 8'h00;
            last_reg   <= 1'b0;
            trial      <= 8'h00;
            sample     <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        state_reg  <= ST_SAMP;
                        period_reg <= 4'h0;
                        code_reg   <= 8'h00;
                        mask_reg   <= 8'h00;
                        last_reg   <= 1'b0;
                        sample     <= 1'b1;
                    end
                end
                ST_SAMP, ST_CONV:
                begin
                    if (stop)
                    begin
                        state_reg <= ST_IDLE; // keep partial bits
                        sample    <= 1'b0;
                        aborted   <= 1'b1;
                    end
                    else if (tick)
                    begin
                        period_reg <= period_reg + 4'h1;
                        if (state_reg == ST_SAMP)
                        begin
                            state_reg <= ST_CONV;
                            sample    <= 1'b0;
                            probe_reg <= 8'h80;
                            trial     <= 8'h80;
                        end
                        else if (probe_reg != 8'h00)
                        begin
                            // keep the trial bit when input is above it
                            code_reg  <= cmp_above ? trial : (trial & ~probe_reg);
                            mask_reg  <= mask_reg | probe_reg;
                            last_reg  <= cmp_above;
                            probe_reg <= probe_reg >> 1;
                            trial     <= (cmp_above ? trial : (trial & ~probe_reg))
                                         | (probe_reg >> 1);
                        end
                        if (period_reg == `ACC_PERIODS - 4'h1)
                        begin
                            state_reg <= ST_IDLE;
                            done      <= 1'b1;
                        end
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> src/acc_tad_gen.v
`timescale 1ns/10ps
`default_nettype none
`include "acc_defines.vh"
module acc_tad_gen
(
    input  wire       aclk,
    input  wire       aresetn,
    input  wire [2:0] clock_select,
    input  wire       rc_tick,
    input  wire       sleep_active,
    input  wire       run,
    output reg        tick
);
    reg  [5:0] div_reg;
    wire       use_rc;

    // terminal count of the system clock divider for each selection
    function [5:0] div_last;
        input [2:0] sel;
        begin
            case (sel)
                `ACC_CKS_DIV2:  div_last = 6'h01;
                `ACC_CKS_DIV4:  div_last = 6'h03;
                `ACC_CKS_DIV8:  div_last = 6'h07;
                `ACC_CKS_DIV16: div_last = 6'h0f;
                `ACC_CKS_DIV32: div_last = 6'h1f;
                `ACC_CKS_DIV64: div_last = 6'h3f;
                default:        div_last = 6'h01;
            endcase
        end
    endfunction

    assign use_rc = (clock_select[1:0] == 2'h3); // x11 picks the rc clock

    // divider restarts with each conversion so the first period is whole
    always @(posedge aclk)
    begin
        if (!aresetn || !run)
        begin
            // preset to one: the registered tick costs a cycle
            div_reg <= 6'h01;
            tick    <= 1'b0;
        end
        else if (use_rc)
        begin
            div_reg <= 6'h00;
            tick    <= rc_tick; // rc clock keeps running in sleep
        end
        else if (sleep_active)
        begin
            tick <= 1'b0; // system clock halted in sleep
        end
        else if (div_reg == div_last(clock_select))
        begin
            div_reg <= 6'h00;
            tick    <= 1'b1;
        end
        else
        begin
            div_reg <= div_reg + 6'h01;
            tick    <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> verif/acc_analog_model.sv
`timescale 1ns/10ps
`default_nettype none
module acc_analog_model
(
    input  wire logic       aclk,
    input  wire logic       converter_on,
    input  wire logic       sample_hold,
    input  wire logic [3:0] channel_select,
    input  wire logic [7:0] dac_trial,
    input  wire logic [7:0] level_base,
    output logic            cmp_above
);
    logic [7:0] held = 8'h00;
    logic       churn = 1'b0;
    // each channel shows its own level, captured while sampling
    always @(posedge aclk)
    begin
        churn <= ~churn;
        if (converter_on && sample_hold)
            held <= level_base ^ {channel_select, 4'h0};
    end
    // unpowered comparator is meaningless, so it wanders
    assign cmp_above = converter_on ? (held >= dac_trial) : churn;
endmodule
`default_nettype wire

// >>> verif/acc_conv_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module acc_conv_ctrl_monitor
(
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_bvalid,
    input wire logic       rc_tick,
    input wire logic       sleep_active,
    input wire logic       converter_on,
    input wire logic [3:0] channel_select,
    input wire logic       sample_hold,
    input wire logic [7:0] dac_trial,
    input wire logic       conv_irq,
    input wire logic       wake_request
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // reset must leave the converter off and quiet
    a_reset_quiet: assert property (disable iff (1'b0)
        !aresetn |=> !converter_on && !sample_hold && !conv_irq) else $error("active after reset");
    a_off_no_sample: assert property (!converter_on |-> !sample_hold)
        else $error("sampling while off");
    // in sleep only the rc tick may end the sample period
    a_sleep_rc_only: assert property (sleep_active && $past(sleep_active) && $fell(sample_hold)
        |-> $past(rc_tick) || $past(rc_tick, 2) || $past(rc_tick, 3)) else $error("sleep progress");
    a_msb_trial: assert property ($fell(sample_hold) && converter_on
        |-> ##[0:1] dac_trial == 8'h80) else $error("first trial not msb");
    a_chan_range: assert property (channel_select < 4'he)
        else $error("channel out of range");
    a_wake_cause: assert property (wake_request |-> conv_irq || $past(conv_irq))
        else $error("wake without irq");
    a_wake_sleep: assert property ($rose(wake_request) |-> sleep_active || $past(sleep_active))
        else $error("wake while awake");
    a_irq_wakes: assert property (conv_irq && $past(conv_irq) && sleep_active
        && $past(sleep_active) |-> wake_request) else $error("irq in sleep did not wake");
    // flag is never cleared by hardware, so the irq drops only after a write
    a_irq_by_sw: assert property ($fell(conv_irq)
        |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("irq dropped by itself");
    c_sample: cover property ($rose(sample_hold));
    c_wake: cover property ($rose(wake_request));
    c_irq_clear: cover property ($fell(conv_irq));
endmodule
bind acc_conv_ctrl acc_conv_ctrl_monitor i_acc_conv_ctrl_monitor (.*);
`default_nettype wire

// >>> verif/acc_conv_ctrl_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "acc_defines.vh"
module acc_conv_ctrl_test;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, unmapped_rd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        sleep_active = 1'b0, cmp_above, converter_on, sample_hold;
    logic        conv_irq, wake_request, rc_free = 1'b1, rc_man = 1'b0, rc_free_tick = 1'b0;
    logic [3:0]  channel_select, ch;
    logic [7:0]  dac_trial, level_base = 8'h00, v, lvl;
    logic [1:0]  rc_cnt = 2'h0;
    logic [2:0]  code;
    logic [34:0] e;
    logic [34:0] rq[$];
    logic [1:0]  bq[$];
    int          sh_cnt = 0, sh_width = 0, n_errors = 0, cmp_count = 0, seed;
    wire logic   rc_tick;

    assign rc_tick = rc_free ? rc_free_tick : rc_man;
    always #5 aclk = ~aclk;
    acc_conv_ctrl i_acc_conv_ctrl (.*);
    acc_analog_model i_acc_analog_model (.*);

    // free rc tick every four cycles, stopped for hand-stepped aborts
    always @(posedge aclk)
    begin
        rc_cnt <= rc_cnt + 2'h1;
        rc_free_tick <= (rc_cnt == 2'h3);
        if (sample_hold)
            sh_cnt <= sh_cnt + 1;
        else if (sh_cnt != 0)
        begin
            sh_width <= sh_cnt;
            sh_cnt <= 0;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // responses are judged as they appear, oldest note first
    always @(posedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready)
        begin
            e = rq.pop_front();
            if (e[34])
            begin
                check("rdata", s_axi_rdata, e[31:0]);
                check("rresp", 32'(s_axi_rresp), 32'(e[33:32]));
            end
        end
        if (s_axi_bvalid && s_axi_bready)
            check("bresp", 32'(s_axi_bresp), 32'(bq.pop_front()));
    end

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            if (s_axi_awready)
            begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready)
            begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        // bready stays up so a following write never re-drives it in one step
        do @(posedge aclk); while (!s_axi_bvalid);
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [31:0] x, input logic [1:0] r,
                            input logic c, output logic [31:0] d);
        rq.push_back({c, r, x});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        // rready stays up for the same reason as bready
        d = s_axi_rdata;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] d;
        axi_read(a, x, `ACC_RESP_OKAY, 1'b1, d);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi_write(a, d, `ACC_RESP_OKAY);
    endtask

    // poll the go bit; a bounded count keeps a stuck conversion visible
    task automatic wait_idle();
        logic [31:0] d;
        int n;
        d = 32'h2;
        n = 0;
        while (d[1] && n < 400)
        begin
            axi_read(`ACC_OFS_CTRL_A, 32'h0, `ACC_RESP_OKAY, 1'b0, d);
            n++;
        end
        check("go_idle", 32'(d[1]), 32'h0);
    endtask

    task automatic rc_pulse();
        rc_man <= 1'b1;
        @(posedge aclk);
        rc_man <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #200000;
        n_errors++;
        $display("watchdog expired");
        finish_test();
    end

    initial
    begin
        seed = 29367;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 5; i++)
            rd(8'(4 * i), 32'h0);
        wr(`ACC_OFS_CTRL_A, 32'h3);
        rd(`ACC_OFS_CTRL_A, 32'h1);
        check("converter_on", 32'(converter_on), 32'h1);
        $display("test power_up done");
        // every clock choice; the rc ones run in sleep with the irq enabled
        for (int c = 0; c < 8; c++)
        begin
            code = 3'(c);
            ch = 4'($unsigned($random(seed)) % 14);
            v = 8'($random(seed));
            lvl = v ^ {ch, 4'h0};
            level_base <= v;
            sleep_active <= (code[1:0] == 2'h3);
            wr(`ACC_OFS_ENABLE, 32'(code[0]));
            wr(`ACC_OFS_CTRL_B, {25'h0, code, 4'h0});
            wr(`ACC_OFS_CTRL_A, {26'h0, ch, 2'h3});
            check("channel", 32'(channel_select), 32'(ch));
            wait_idle();
            rd(`ACC_OFS_CTRL_A, {26'h0, ch, 2'h1});
            rd(`ACC_OFS_RESULT, 32'(lvl));
            rd(`ACC_OFS_FLAG, 32'h1);
            check("conv_irq", 32'(conv_irq), 32'(code[0]));
            check("wake", 32'(wake_request), 32'(code[1:0] == 2'h3));
            if (code[1:0] != 2'h3)
                check("sample_len", sh_width, 32'd2 << (code[2] + 2 * code[1:0]));
            wr(`ACC_OFS_FLAG, 32'h0);
            sleep_active <= 1'b0;
            repeat (2) @(posedge aclk);
            check("conv_irq", 32'(conv_irq), 32'h0);
        end
        $display("test clock_select done");
        // divided clock must stand still in sleep
        sleep_active <= 1'b1;
        wr(`ACC_OFS_CTRL_B, 32'h0);
        wr(`ACC_OFS_CTRL_A, 32'h3);
        repeat (40) @(posedge aclk);
        rd(`ACC_OFS_CTRL_A, 32'h3);
        sleep_active <= 1'b0;
        wait_idle();
        rd(`ACC_OFS_RESULT, 32'(v));
        $display("test sleep_freeze done");
        // hand-stepped rc ticks, then abort after k resolved bits
        rc_free <= 1'b0;
        wr(`ACC_OFS_CTRL_B, 32'h30);
        for (int k = 0; k < 8; k += 3)
        begin
            wr(`ACC_OFS_CTRL_A, 32'h3);
            repeat (k + 1) rc_pulse();
            wr(`ACC_OFS_CTRL_A, 32'h1);
            lvl = v & (8'hff << (8 - k));
            if (k > 0 && v[8 - k])
                lvl = lvl | (8'hff >> k);
            rd(`ACC_OFS_RESULT, 32'(lvl));
        end
        $display("test abort done");
        axi_write(8'h20, 32'hff, `ACC_RESP_SLVERR);
        axi_read(8'h20, 32'h0, `ACC_RESP_SLVERR, 1'b1, unmapped_rd);
        $display("test unmapped done");
        // reset in mid-conversion
        wr(`ACC_OFS_CTRL_A, 32'h3);
        rc_pulse();
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`ACC_OFS_CTRL_A, 32'h0);
        rd(`ACC_OFS_RESULT, 32'h0);
        check("converter_on", 32'(converter_on), 32'h0);
        $display("test reset done");
        finish_test();
    end
endmodule
`default_nettype wire
